// ===== core/erxdma_pkg.sv
// ==========================================================
// Shared constants for the receive buffer DMA
package erxdma_pkg;
	// Register byte offsets on the APB slave
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_NETCFG = 8'h04;
	localparam logic [7:0] OFS_DMACFG = 8'h08;
	localparam logic [7:0] OFS_RXQB = 8'h0c;
	localparam logic [7:0] OFS_STAT = 8'h10;
	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] NETCFG_RST = 32'h0000_0000;
	localparam logic [31:0] DMACFG_RST = 32'h0002_0000;
	localparam logic [31:0] RXQB_RST = 32'h0000_0000;
	// Field positions
	localparam int CTRL_RXEN = 0;
	localparam int STAT_BNA = 0;
	localparam int STAT_BUSY = 1;
	localparam int NCF_JUMBO = 3;
	localparam int NCF_OFS_LO = 14;
	localparam int NCF_CSUM = 24;
	localparam int NCF_IGN_FCS = 26;
	localparam int DCF_BS_LO = 16;
	localparam int BS_SHIFT = 6;
	localparam logic [14:0] BS_MAX_BYTES = 15'h4000;
	// Descriptor layout
	localparam int DW0_OWN = 0;
	localparam int DW0_WRAP = 1;
	localparam logic [31:0] DESC_STRIDE = 32'h0000_0008;
	localparam logic [31:0] DW1_OFS = 32'h0000_0004;
	localparam int ST_BCAST = 31;
	localparam int ST_MHASH = 30;
	localparam int ST_UHASH = 29;
	localparam int ST_SA = 27;
	localparam int ST_SA_LO = 25;
	localparam int ST_TID = 24;
	localparam int ST_TID_LO = 22;
	localparam int ST_VLAN = 21;
	localparam int ST_PRIO = 20;
	localparam int ST_VPRI_LO = 17;
	localparam int ST_CFI = 16;
	localparam int ST_EOF = 15;
	localparam int ST_SOF = 14;
	localparam int ST_LEN13 = 13;
	// Bus operations, index 0 has the highest priority
	localparam int N_OPS = 6;
	localparam logic [2:0] OP_RXDW = 3'h0;
	localparam logic [2:0] OP_RXDR = 3'h1;
	localparam logic [2:0] OP_TXDW = 3'h2;
	localparam logic [2:0] OP_TXDR = 3'h3;
	localparam logic [2:0] OP_RXWR = 3'h4;
	localparam logic [2:0] OP_TXRD = 3'h5;
	// AHB encodings
	localparam logic [1:0] HTRANS_IDLE = 2'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_BYTE = 3'h0;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [2:0] HBURST_SINGLE = 3'h0;
	typedef enum logic [1:0] {A_IDLE, A_ADDR, A_DATA, A_DONE} erxdma_ahb_state_t;
	typedef enum logic [2:0] {R_IDLE, R_FETCH, R_DATA, R_STAT, R_USED, R_DROP} erxdma_rx_state_t;
endpackage

// ===== core/erxdma_top.sv
// Summary of operation
// - Bus grants follow fixed six-level operation priority
// - Buffer size 64 B to 16 KB, 128 default
// - Descriptors fetched from queue pointer, base programmed
// - Descriptor is address word plus status word
// - Overflowed buffer status zero except start flag
// - Used buffer gets bit zero set
// - Frame continues in next buffers; last gets status
// - First buffer offset 0-3 bytes shrinks its length
// - Address word bits 31:2 give buffer start
// - Wrap bit marks last descriptor of list
// - Write buffer only if ownership bit clear
// - Status bits 31/30/29: broadcast, multicast, unicast
// - Bit 27 plus 26:25 report specific-address match
// - Specific-address priority four down to one
// - Offload off: bit 24 type-ID match flag
// - Offload on: bit 24 SNAP without CFI tag
// - Type-ID code 23:22 only when offload off
// - Offload on: 23:22 give checksum result
// - Bit 15 end, bit 14 start of frame
// - Pointer steps two words, wraps to base
// - Length in 12:0, bit 13 extends in jumbo
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module erxdma_top
	import erxdma_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [2:0] hburst,
	output logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic hready,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_last,
	output logic rx_ready,
	input wire logic rx_bcast,
	input wire logic rx_mhash,
	input wire logic rx_uhash,
	input wire logic [3:0] rx_sa_match,
	input wire logic [3:0] rx_tid_match,
	input wire logic rx_snap,
	input wire logic rx_vlan,
	input wire logic rx_prio_tag,
	input wire logic [2:0] rx_vlan_pri,
	input wire logic rx_cfi,
	input wire logic [1:0] rx_csum,
	input wire logic rx_fcs_bad,
	input wire logic tx_desc_wr_req,
	input wire logic [31:0] tx_desc_wr_addr,
	input wire logic [31:0] tx_desc_wdata,
	input wire logic tx_desc_rd_req,
	input wire logic [31:0] tx_desc_rd_addr,
	input wire logic tx_data_rd_req,
	input wire logic [31:0] tx_data_rd_addr,
	output logic tx_desc_wr_done,
	output logic tx_desc_rd_done,
	output logic tx_data_rd_done,
	output logic [31:0] tx_rdata
);

	// ==========================================================
	// Helpers
	// Highest set match wins, so register 4 beats register 1
	function automatic logic [1:0] enc_top(input logic [3:0] m);
		logic [1:0] r;
		r = 2'h0;
		for (int i = 0; i < 4; i++)
			if (m[i])
				r = 2'(i);
		return r;
	endfunction

	// Lowest index pending wins
	function automatic logic [2:0] pick(input logic [N_OPS-1:0] r);
		logic [2:0] g;
		g = 3'h0;
		for (int i = N_OPS - 1; i >= 0; i--)
			if (r[i])
				g = 3'(i);
		return g;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return a == OFS_CTRL || a == OFS_NETCFG || a == OFS_DMACFG ||
			a == OFS_RXQB || a == OFS_STAT;
	endfunction

	// ==========================================================
	// APB register file
	logic [31:0] ctrl_q, ctrl_d, netcfg_q, netcfg_d, dmacfg_q, dmacfg_d, base_q, base_d;
	logic [31:0] prdata_q, prdata_d;
	logic bna_q, bna_d, bna_set, base_wr;
	logic [31:0] ptr_q;
	erxdma_rx_state_t rs_q, rs_d;
	logic wr_acc, rx_en;

	assign wr_acc = psel && penable && pwrite && mapped(paddr);
	assign rx_en = ctrl_q[CTRL_RXEN];
	// Base is frozen while receive runs, so the walk is never torn
	assign base_wr = wr_acc && paddr == OFS_RXQB && !rx_en;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped(paddr);
	assign prdata = prdata_q;

	// Next register values and read data, fetched in the setup cycle
	always_comb
	begin
		ctrl_d = ctrl_q;
		netcfg_d = netcfg_q;
		dmacfg_d = dmacfg_q;
		base_d = base_q;
		bna_d = bna_q;
		prdata_d = prdata_q;
		if (wr_acc && paddr == OFS_CTRL)
			ctrl_d = pwdata;
		if (wr_acc && paddr == OFS_NETCFG)
			netcfg_d = pwdata;
		if (wr_acc && paddr == OFS_DMACFG)
			dmacfg_d = pwdata;
		if (base_wr)
			base_d = {pwdata[31:2], 2'h0};
		if (wr_acc && paddr == OFS_STAT && pwdata[STAT_BNA])
			bna_d = 1'b0;
		if (bna_set)
			bna_d = 1'b1;
		if (psel && !penable)
		begin
			unique case (paddr)
				OFS_CTRL: prdata_d = ctrl_q;
				OFS_NETCFG: prdata_d = netcfg_q;
				OFS_DMACFG: prdata_d = dmacfg_q;
				OFS_RXQB: prdata_d = ptr_q;
				OFS_STAT: prdata_d = {30'h0, rs_q != R_IDLE, bna_q};
				default: prdata_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= CTRL_RST;
			netcfg_q <= NETCFG_RST;
			dmacfg_q <= DMACFG_RST;
			base_q <= RXQB_RST;
			bna_q <= 1'b0;
			prdata_q <= 32'h0;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			netcfg_q <= netcfg_d;
			dmacfg_q <= dmacfg_d;
			base_q <= base_d;
			bna_q <= bna_d;
			prdata_q <= prdata_d;
		end
	end

	// ==========================================================
	// AHB master with fixed-priority arbiter
	erxdma_ahb_state_t as_q, as_d;
	logic [N_OPS-1:0] req;
	logic [2:0] op_q, op_d, sel;
	logic [31:0] haddr_q, haddr_d, hwdata_q, hwdata_d, rdata_q, rdata_d;
	logic hwrite_q, hwrite_d;
	logic [2:0] hsize_q, hsize_d;
	logic [31:0] rx_waddr, rx_wdata;
	logic done, rx_rd_op;

	assign sel = pick(req);
	assign done = as_q == A_DONE;
	assign htrans = (as_q == A_ADDR) ? HTRANS_NONSEQ : HTRANS_IDLE;
	assign hburst = HBURST_SINGLE;
	assign haddr = haddr_q;
	assign hwrite = hwrite_q;
	assign hsize = hsize_q;
	assign hwdata = hwdata_q;
	assign tx_rdata = rdata_q;
	assign tx_desc_wr_done = done && op_q == OP_TXDW;
	assign tx_desc_rd_done = done && op_q == OP_TXDR;
	assign tx_data_rd_done = done && op_q == OP_TXRD;
	assign req[OP_RXDR] = rs_q == R_FETCH;
	assign req[OP_TXDW] = tx_desc_wr_req;
	assign req[OP_TXDR] = tx_desc_rd_req;
	assign req[OP_RXWR] = rs_q == R_DATA && rx_valid;
	assign req[OP_TXRD] = tx_data_rd_req;
	assign req[OP_RXDW] = rs_q == R_STAT || rs_q == R_USED;
	assign rx_rd_op = sel == OP_RXDR;

	// One single transfer at a time; the done cycle lets requesters drop
	always_comb
	begin
		as_d = as_q;
		op_d = op_q;
		haddr_d = haddr_q;
		hwrite_d = hwrite_q;
		hsize_d = hsize_q;
		hwdata_d = hwdata_q;
		rdata_d = rdata_q;
		unique case (as_q)
			A_IDLE:
				if (|req)
				begin
					as_d = A_ADDR;
					op_d = sel;
					hwrite_d = 1'b1;
					hsize_d = HSIZE_WORD;
					hwdata_d = rx_wdata;
					haddr_d = rx_waddr;
					unique case (sel)
						OP_TXDW:
						begin
							haddr_d = tx_desc_wr_addr;
							hwdata_d = tx_desc_wdata;
						end
						OP_TXDR:
						begin
							haddr_d = tx_desc_rd_addr;
							hwrite_d = 1'b0;
						end
						OP_TXRD:
						begin
							haddr_d = tx_data_rd_addr;
							hwrite_d = 1'b0;
						end
						OP_RXWR:
						begin
							hsize_d = HSIZE_BYTE;
							hwdata_d = {4{rx_data}};
						end
						default: hwrite_d = !rx_rd_op;
					endcase
				end
			A_ADDR:
				if (hready)
					as_d = A_DATA;
			A_DATA:
				if (hready)
				begin
					as_d = A_DONE;
					rdata_d = hrdata;
				end
			A_DONE: as_d = A_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			as_q <= A_IDLE;
			op_q <= OP_RXDW;
			haddr_q <= 32'h0;
			hwrite_q <= 1'b0;
			hsize_q <= HSIZE_WORD;
			hwdata_q <= 32'h0;
			rdata_q <= 32'h0;
		end
		else
		begin
			as_q <= as_d;
			op_q <= op_d;
			haddr_q <= haddr_d;
			hwrite_q <= hwrite_d;
			hsize_q <= hsize_d;
			hwdata_q <= hwdata_d;
			rdata_q <= rdata_d;
		end
	end

	// ==========================================================
	// Receive buffer manager
	logic [31:0] ptr_d, buf_q, buf_d, st_q, st_d, fstat;
	logic wrap_q, wrap_d, sof_q, sof_d, eof_q, eof_d;
	logic [14:0] fill_q, fill_d, cap_q, cap_d, bsize, ofs;
	logic [13:0] len_q, len_d, len_n;
	logic [7:0] bs_field;
	logic csum_on;

	assign bs_field = dmacfg_q[DCF_BS_LO +: 8];
	// Field counts 64-byte units; zero stands for the 16 KB top
	assign bsize = (bs_field == 8'h0) ? BS_MAX_BYTES : 15'(bs_field) << BS_SHIFT;
	assign ofs = {13'h0, netcfg_q[NCF_OFS_LO +: 2]};
	assign csum_on = netcfg_q[NCF_CSUM];
	assign len_n = len_q + 14'h1;
	assign rx_ready = (rs_q == R_DROP) || (done && op_q == OP_RXWR);
	assign bna_set = rs_q == R_FETCH && done && op_q == OP_RXDR && rdata_q[DW0_OWN];

	// Descriptor write address and data
	always_comb
	begin
		rx_waddr = ptr_q;
		rx_wdata = {buf_q[31:2], wrap_q, 1'b1};
		if (rs_q == R_STAT)
		begin
			rx_waddr = ptr_q + DW1_OFS;
			rx_wdata = eof_q ? st_q : 32'(sof_q) << ST_SOF;
		end
		else if (rs_q == R_DATA)
			rx_waddr = buf_q + 32'(fill_q) + (sof_q ? 32'(ofs) : 32'h0);
	end

	// Whole-frame status, built as the last byte is stored
	always_comb
	begin
		fstat = 32'h0;
		fstat[ST_BCAST] = rx_bcast;
		fstat[ST_MHASH] = rx_mhash;
		fstat[ST_UHASH] = rx_uhash;
		fstat[ST_SA] = |rx_sa_match;
		fstat[ST_SA_LO +: 2] = enc_top(rx_sa_match);
		if (csum_on)
		begin
			fstat[ST_TID] = rx_snap && (!rx_vlan || !rx_cfi);
			fstat[ST_TID_LO +: 2] = rx_csum;
		end
		else
		begin
			fstat[ST_TID] = |rx_tid_match;
			fstat[ST_TID_LO +: 2] = enc_top(rx_tid_match);
		end
		fstat[ST_VLAN] = rx_vlan;
		fstat[ST_PRIO] = rx_prio_tag;
		fstat[ST_VPRI_LO +: 3] = rx_vlan_pri;
		fstat[ST_CFI] = rx_cfi;
		fstat[ST_EOF] = 1'b1;
		fstat[ST_SOF] = sof_q;
		fstat[12:0] = len_n[12:0];
		if (netcfg_q[NCF_JUMBO])
			fstat[ST_LEN13] = len_n[13];
		else if (netcfg_q[NCF_IGN_FCS])
			fstat[ST_LEN13] = rx_fcs_bad;
	end

	// Frame walk over the descriptor ring
	always_comb
	begin
		rs_d = rs_q;
		ptr_d = ptr_q;
		buf_d = buf_q;
		wrap_d = wrap_q;
		sof_d = sof_q;
		eof_d = eof_q;
		fill_d = fill_q;
		cap_d = cap_q;
		len_d = len_q;
		st_d = st_q;
		if (base_wr)
			ptr_d = {pwdata[31:2], 2'h0};
		unique case (rs_q)
			R_IDLE:
				if (rx_en && rx_valid)
				begin
					rs_d = R_FETCH;
					sof_d = 1'b1;
					eof_d = 1'b0;
					len_d = 14'h0;
				end
			R_FETCH:
				if (done && op_q == OP_RXDR)
				begin
					if (rdata_q[DW0_OWN])
						rs_d = R_DROP;
					else
					begin
						rs_d = R_DATA;
						buf_d = {rdata_q[31:2], 2'h0};
						wrap_d = rdata_q[DW0_WRAP];
						fill_d = 15'h0;
						cap_d = sof_q ? bsize - ofs : bsize;
					end
				end
			R_DATA:
				if (done && op_q == OP_RXWR)
				begin
					fill_d = fill_q + 15'h1;
					len_d = len_n;
					if (rx_last)
					begin
						rs_d = R_STAT;
						eof_d = 1'b1;
						st_d = fstat;
					end
					else if (fill_q + 15'h1 == cap_q)
						rs_d = R_STAT;
				end
			R_STAT:
				if (done && op_q == OP_RXDW)
					rs_d = R_USED;
			R_USED:
				if (done && op_q == OP_RXDW)
				begin
					ptr_d = wrap_q ? base_q : ptr_q + DESC_STRIDE;
					sof_d = 1'b0;
					rs_d = eof_q ? R_IDLE : R_FETCH;
				end
			R_DROP:
				if (rx_valid && rx_last)
					rs_d = R_IDLE;
			default: rs_d = R_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rs_q <= R_IDLE;
			ptr_q <= RXQB_RST;
			buf_q <= 32'h0;
			wrap_q <= 1'b0;
			sof_q <= 1'b0;
			eof_q <= 1'b0;
			fill_q <= 15'h0;
			cap_q <= 15'h0;
			len_q <= 14'h0;
			st_q <= 32'h0;
		end
		else
		begin
			rs_q <= rs_d;
			ptr_q <= ptr_d;
			buf_q <= buf_d;
			wrap_q <= wrap_d;
			sof_q <= sof_d;
			eof_q <= eof_d;
			fill_q <= fill_d;
			cap_q <= cap_d;
			len_q <= len_d;
			st_q <= st_d;
		end
	end

endmodule
`default_nettype wire

// ===== verif/erxdma_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Memory on the system bus
module erxdma_mem_model
	import erxdma_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic slow,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hready
);
	logic [31:0] mem [0:1023]; // Ring and buffers
	logic [31:0] a_q, last_q;
	logic dph_q, wr_q, byte_q;
	logic [1:0] cnt_q;
	// Slow mode accepts one edge in four
	assign hready = !slow || cnt_q == 2'h3;
	// Idle data lines show the inverse of the last word
	assign hrdata = dph_q ? mem[a_q[11:2]] : ~last_q;
	// Data phase follows an accepted address phase
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			{a_q, last_q, dph_q, wr_q, byte_q, cnt_q} <= '0;
		end
		else
		begin
			cnt_q <= cnt_q + 2'h1;
			if (hready)
			begin
				if (dph_q && wr_q && byte_q)
					mem[a_q[11:2]][{a_q[1:0], 3'h0} +: 8] <= hwdata[{a_q[1:0], 3'h0} +: 8];
				else if (dph_q && wr_q)
					mem[a_q[11:2]] <= hwdata;
				if (dph_q)
					last_q <= hrdata;
				dph_q <= htrans == HTRANS_NONSEQ;
				{a_q, wr_q, byte_q} <= {haddr, hwrite, hsize == HSIZE_BYTE};
			end
		end
	end
endmodule
`default_nettype wire

// ===== verif/erxdma_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Bus master checks
module erxdma_properties
	import erxdma_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [2:0] hburst,
	input wire logic hready,
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire logic tx_desc_wr_req,
	input wire logic tx_desc_wr_done,
	input wire logic tx_data_rd_done
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Address phase accepted by the slave
	sequence s_grant;
		htrans == HTRANS_NONSEQ && hready;
	endsequence
	a_one_xfer: assert property (s_grant |=> (htrans == HTRANS_IDLE) [*3])
		else $error("transfers overlap");
	a_addr_held: assert property (htrans == HTRANS_NONSEQ && !hready |=>
		htrans == HTRANS_NONSEQ && $stable(haddr)) else $error("address dropped");
	a_single_burst: assert property (htrans == HTRANS_NONSEQ |-> hburst == HBURST_SINGLE)
		else $error("burst not single");
	a_desc_aligned: assert property (htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD |->
		haddr[1:0] == 2'h0) else $error("word unaligned");
	a_byte_write: assert property (htrans == HTRANS_NONSEQ && hsize == HSIZE_BYTE |->
		hwrite) else $error("byte read");
	a_pop_valid: assert property (rx_ready |-> rx_valid)
		else $error("pop without byte");
	a_prio_order: assert property (tx_data_rd_done |->
		!(tx_desc_wr_req && $past(tx_desc_wr_req, 3))) else $error("data read overtook");
	a_done_pulse: assert property (tx_desc_wr_done |=> !tx_desc_wr_done)
		else $error("done too long");
endmodule
bind erxdma_top erxdma_properties u_prop (.pclk, .presetn, .haddr, .htrans, .hwrite, .hsize,
	.hburst, .hready, .rx_valid, .rx_ready, .tx_desc_wr_req, .tx_desc_wr_done, .tx_data_rd_done);
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Receive buffer DMA bench
module tb
	import erxdma_pkg::*;
;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, hready;
	logic [7:0] paddr = 0, rx_data = 0;
	logic [31:0] pwdata = 0, hrdata, prdata, haddr, hwdata, tx_rdata, v, v2, wa = 0;
	logic pready, pslverr, hwrite, rx_ready, tx_desc_wr_done, tx_desc_rd_done, tx_data_rd_done;
	logic [1:0] htrans, rx_csum = 0;
	logic [2:0] hsize, hburst, rx_vlan_pri = 0;
	logic rx_valid = 0, rx_last = 0, rx_bcast = 0, rx_mhash = 0, rx_uhash = 0, rx_snap = 0;
	logic rx_vlan = 0, rx_prio_tag = 0, rx_cfi = 0, rx_fcs_bad = 0, wdph = 0;
	logic [3:0] rx_sa_match = 0, rx_tid_match = 0;
	logic tx_desc_wr_req = 0, tx_desc_rd_req = 0, tx_data_rd_req = 0;
	logic [31:0] tx_desc_wr_addr = 32'h200, tx_desc_wdata = 0, tx_desc_rd_addr = 32'h200;
	logic [31:0] tx_data_rd_addr = 32'h204, base = 32'h100;
	logic [31:0] dbuf [2] = '{32'h400, 32'h440};
	bit dwrap [2] = '{1'b0, 1'b1};
	bit csum_on = 0, ign_fcs = 0, jumbo = 0;
	int failures = 0, n_checks = 0, seed = 1340, cyc = 0, pi = 0, ofs = 2, bsz = 64;
	logic [31:0] rdq [$];
	logic [63:0] wq [$];
	erxdma_top dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .haddr, .htrans, .hwrite, .hsize, .hburst, .hwdata, .hrdata, .hready,
		.rx_valid, .rx_data, .rx_last, .rx_ready, .rx_bcast, .rx_mhash, .rx_uhash, .rx_sa_match,
		.rx_tid_match, .rx_snap, .rx_vlan, .rx_prio_tag, .rx_vlan_pri, .rx_cfi, .rx_csum,
		.rx_fcs_bad, .tx_desc_wr_req, .tx_desc_wr_addr, .tx_desc_wdata, .tx_desc_rd_req,
		.tx_desc_rd_addr, .tx_data_rd_req, .tx_data_rd_addr, .tx_desc_wr_done,
		.tx_desc_rd_done, .tx_data_rd_done, .tx_rdata);
	erxdma_mem_model u_mem (.pclk, .presetn, .slow, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hrdata, .hready);
	always #2 pclk = ~pclk;
	task automatic check(logic [63:0] got, logic [63:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		if (failures == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Hang guard
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			report_and_stop();
		end
	end
	// Register reads and error flag
	always @(posedge pclk)
	begin
		if (psel && penable && pready && !pwrite)
			check(prdata, rdq.pop_front());
		if (psel && penable && pready)
			check(pslverr, paddr > OFS_STAT);
	end
	// Every bus write against the oldest note
	always @(posedge pclk)
	begin
		if (wdph && hready)
			if (wq.size() == 0)
				check(1, 0);
			else
				check({wa, hwdata}, wq.pop_front());
		if (hready)
			{wdph, wa} <= {htrans == HTRANS_NONSEQ && hwrite, haddr};
	end
	function automatic logic [1:0] pick(logic [3:0] m);
		return m[3] ? 2'h3 : m[2] ? 2'h2 : m[1] ? 2'h1 : 2'h0;
	endfunction
	// Status word for one buffer
	function automatic logic [31:0] stat(logic [20:0] r, int n, bit last, bit first);
		logic [31:0] s;
		s = '0;
		s[ST_SOF] = first;
		if (last)
		begin
			s[31:29] = r[20:18];
			if (|r[17:14])
				s[27:25] = {1'b1, pick(r[17:14])};
			if (csum_on)
				s[24:22] = {r[9] && !(r[8] && r[3]), r[2:1]};
			else if (|r[13:10])
				s[24:22] = {1'b1, pick(r[13:10])};
			s[21:15] = {r[8:3], 1'b1};
			// Jumbo mode takes bit 13 for length, ahead of the FCS flag
			s[13] = jumbo ? n[13] : ign_fcs && r[0];
			s[12:0] = n[12:0];
		end
		return s; // Bit 28 stays zero
	endfunction
	task automatic apb(bit w, logic [7:0] a, logic [31:0] d, logic [31:0] e);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		if (!w)
			rdq.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		{psel, penable} <= 2'b00;
	endtask
	// Notes all writes of a frame, then streams it
	task automatic frame(int n, bit drop);
		logic [20:0] r;
		logic [7:0] b [$];
		int fill, off, first;
		r = $random(seed);
		{fill, off, first} = {32'd0, ofs, 32'd1};
		for (int k = 0; k < n; k++)
			b.push_back($random(seed));
		for (int k = 0; k < n && !drop; k++)
		begin
			wq.push_back({dbuf[pi] + off + fill, {4{b[k]}}});
			fill++;
			if (fill == bsz - off || k == n - 1)
			begin
				wq.push_back({base + 8 * pi + 4, stat(r, n, k == n - 1, first)});
				wq.push_back({base + 8 * pi, dbuf[pi] | {dwrap[pi], 1'b1}});
				pi = dwrap[pi] ? 0 : pi + 1;
				{fill, off, first} = '0;
			end
		end
		@(posedge pclk);
		{rx_bcast, rx_mhash, rx_uhash, rx_sa_match, rx_tid_match, rx_snap, rx_vlan, rx_prio_tag,
			rx_vlan_pri, rx_cfi, rx_csum, rx_fcs_bad} <= r;
		for (int k = 0; k < n; k++)
		begin
			{rx_valid, rx_data, rx_last} <= {1'b1, b[k], k == n - 1};
			@(posedge pclk);
			while (rx_ready !== 1'b1)
				@(posedge pclk);
		end
		{rx_valid, rx_last} <= 2'b00;
		for (int k = 0; k < 4000 && wq.size() > 0; k++)
			@(posedge pclk);
		check(wq.size(), 0);
	endtask
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, OFS_DMACFG, 0, DMACFG_RST);
		apb(0, 8'h14, 0, 0);
		{u_mem.mem['h40], u_mem.mem['h42]} = {32'h400, 32'h442};
		apb(1, OFS_RXQB, base, 0);
		apb(1, OFS_DMACFG, 32'h0001_0000, 0);
		apb(1, OFS_NETCFG, 32'h0000_8000, 0);
		apb(1, OFS_CTRL, 1, 0);
		slow <= 1'b1;
		frame(70, 0);
		apb(1, OFS_RXQB, 32'h300, 0);
		frame(12, 1);
		apb(0, OFS_STAT, 0, 1);
		apb(1, OFS_STAT, 1, 0);
		apb(0, OFS_STAT, 0, 0);
		u_mem.mem['h40] = 32'h400;
		apb(1, OFS_NETCFG, 32'h0500_0000, 0);
		{ofs, csum_on, ign_fcs} = {32'd0, 2'b11};
		slow <= 1'b0;
		frame(10, 0);
		u_mem.mem['h42] = 32'h442;
		apb(1, OFS_NETCFG, 32'h0500_0008, 0);
		jumbo = 1;
		frame(6, 0);
		apb(1, OFS_CTRL, 0, 0);
		apb(0, OFS_RXQB, 0, 32'h100);
		// All three transmit requests at once
		{v, v2} = {$random(seed), $random(seed)};
		u_mem.mem['h81] = v2;
		@(posedge pclk);
		{tx_desc_wr_req, tx_desc_rd_req, tx_data_rd_req, tx_desc_wdata} <= {3'h7, v};
		wq.push_back({32'h200, v});
		for (int k = 2; k >= 0; k--)
		begin
			@(posedge pclk);
			for (int j = 0; j < 400 && {tx_desc_wr_done, tx_desc_rd_done, tx_data_rd_done} == 0; j++)
				@(posedge pclk);
			check({tx_desc_wr_done, tx_desc_rd_done, tx_data_rd_done}, 3'h1 << k);
			if (k < 2)
				check(tx_rdata, k ? v : v2);
			{tx_desc_wr_req, tx_desc_rd_req, tx_data_rd_req} <=
				{tx_desc_wr_req, tx_desc_rd_req, tx_data_rd_req} & ~(3'h1 << k);
		end
		check(wq.size(), 0);
		report_and_stop();
	end
endmodule
`default_nettype wire
